// file: core/svd_pkg.sv
/*
 * Package of the supply-voltage detect control block: register offsets,
 * bit positions, reset values, the reference-settle timing and the states
 * of the reference tracker.
 * Assumes a 32-bit APB bus, where each register takes one aligned word, and
 * a 20 MHz system clock.
 */
package svd_pkg;

    // ==========================================================================
    // Bus and register map
    // ==========================================================================
    localparam int APB_DATA_W = 32;                   // Width of the APB data bus.
    localparam int APB_ADDR_W = 12;                   // Width of the decoded address.
    localparam int CTRL_W = 8;                        // Width of the control register.
    localparam int INT_W = 1;                         // Number of interrupt sources.
    localparam logic [APB_ADDR_W-1:0] OFS_CTRL = 12'h000;   // voltage_detect_control.
    localparam logic [APB_ADDR_W-1:0] OFS_STATUS = 12'h004; // Sticky interrupt status.
    localparam logic [APB_ADDR_W-1:0] OFS_MASK = 12'h008;   // Interrupt mask.

    // ==========================================================================
    // Control register layout
    // ==========================================================================
    localparam int CTRL_DIR_BIT = 7;                  // direction_select.
    localparam int CTRL_RSVD_BIT = 6;                 // Unimplemented, reads zero.
    localparam int CTRL_STABLE_BIT = 5;               // reference_stable, read only.
    localparam int CTRL_EN_BIT = 4;                   // detector_enable.
    localparam int LVL_MSB = 3;                       // Top bit of trip_level.
    localparam int LVL_LSB = 0;                       // Bottom bit of trip_level.
    localparam int LVL_W = LVL_MSB - LVL_LSB + 1;     // Width of trip_level.
    localparam logic [LVL_W-1:0] LVL_EXTERNAL = 4'hf; // Code that selects the external pin.
    localparam logic LVL_RESET_DIR = 1'b0;            // Reset of direction_select.
    localparam logic LVL_RESET_EN = 1'b0;             // Reset of detector_enable.
    localparam logic [LVL_W-1:0] LVL_RESET = 4'h5;    // Reset of trip_level.
    localparam int INT_DETECT_BIT = 0;                // Status and mask bit of detect_flag.

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int CLK_PERIOD_NS = 50;                // pclk period at 20 MHz.
    localparam int STAB_TIME_NS = 20000;              // Reference settle time, least.
    // The settle time is a least time, so it rounds up to whole cycles.
    localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================================
    // Reference tracker states
    // ==========================================================================
    typedef enum logic [1:0] {
        REF_OFF = 2'b00,                              // Detector powered down.
        REF_SETTLE = 2'b01,                           // Reference still settling.
        REF_READY = 2'b10                             // Reference stable, detection live.
    } svd_ref_state_t;

    // Assemble the control register image as software reads it.
    function automatic logic [CTRL_W-1:0] svd_ctrl_image(
        input logic dir,
        input logic stable,
        input logic en,
        input logic [LVL_W-1:0] lvl
    );
        logic [CTRL_W-1:0] img;
        img = '0;
        img[CTRL_DIR_BIT] = dir;
        img[CTRL_STABLE_BIT] = stable;
        img[CTRL_EN_BIT] = en;
        img[LVL_MSB:LVL_LSB] = lvl;
        return img;
    endfunction : svd_ctrl_image

endpackage : svd_pkg

// file: core/svd_sync.sv
/*
 * Two-flop synchroniser for levels that arrive from outside the pclk domain.
 * Assumes the inputs are levels that stay put for at least two pclk cycles;
 * short glitches may be missed, which is what the analog side expects.
 */
`timescale 1ns/1ps

module svd_sync #(
    parameter int WIDTH = 1                    // Number of independent level bits.
) (
    input wire logic pclk,                     // System clock.
    input wire logic presetn,                  // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] async_in,     // Levels from another domain.
    output logic [WIDTH-1:0] sync_out          // Levels safe to use in pclk logic.
);

    // ==========================================================================
    // Synchroniser stages
    // ==========================================================================
    logic [WIDTH-1:0] meta_q;                  // First stage, read only by the second.

    // Both stages reset to zero; only the second stage is ever read outside.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : svd_sync

// file: core/svd_top.sv
/*
 * Control and status logic of the supply-voltage detector: APB register file,
 * reference-settle tracker, crossing detection, sticky interrupt flag and
 * wake-up request.
 * Assumes the analog comparator, divider and reference live outside and that
 * the comparator output is an asynchronous level; sleep_active comes from
 * logic on pclk.
 */
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

module svd_top
    import svd_pkg::*;
#(
    parameter int STAB_CNT = STAB_CYCLES       // Settle time in pclk cycles.
) (
    input wire logic pclk,                          // System clock, 20 MHz.
    input wire logic presetn,                       // Asynchronous reset, active low.
    input wire logic psel,                          // APB select.
    input wire logic penable,                       // APB access phase.
    input wire logic pwrite,                        // APB direction, high for write.
    input wire logic [APB_ADDR_W-1:0] paddr,        // APB byte address.
    input wire logic [APB_DATA_W-1:0] pwdata,       // APB write data.
    input wire logic [3:0] pstrb,                   // APB byte strobes.
    output logic [APB_DATA_W-1:0] prdata,           // APB read data.
    output logic pready,                            // APB ready.
    output logic pslverr,                           // APB error for unmapped address.
    input wire logic supply_at_or_above,            // Comparator: supply at or above trip.
    input wire logic sleep_active,                  // Device is in sleep.
    output logic detector_enable,                   // Powers the analog detector.
    output logic [LVL_W-1:0] trip_level,            // Divider tap selection.
    output logic external_trip_input,               // Route the external pin to comparator.
    output logic reference_stable,                  // Reference has settled.
    output logic detect_irq,                        // Level interrupt.
    output logic wake_request                       // Wake-up request while a crossing holds in sleep.
);

    // ==========================================================================
    // Declarations
    // ==========================================================================
    localparam int CNT_W = $clog2(STAB_CNT + 1);    // Width of the settle counter.
    localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(STAB_CNT); // Count that ends settling.

    logic dir_q;                                    // direction_select.
    logic en_q;                                     // detector_enable.
    logic [LVL_W-1:0] lvl_q;                        // trip_level.
    logic ext_q;                                    // External input selected.
    svd_ref_state_t ref_state_q;                    // Reference tracker state.
    svd_ref_state_t ref_state_d;                    // Next tracker state.
    logic [CNT_W-1:0] stab_cnt_q;                   // Cycles spent settling.
    logic [INT_W-1:0] status_q;                     // Sticky interrupt status.
    logic [INT_W-1:0] status_d;                     // Next status.
    logic [INT_W-1:0] mask_q;                       // Interrupt mask.
    logic [APB_DATA_W-1:0] prdata_q;                // Read data captured in setup.
    logic pslverr_q;                                // Error captured in setup.
    logic irq_q;                                    // Registered interrupt.
    logic wake_q;                                   // Registered wake pulse.
    logic above_s;                                  // Synchronised comparator level.
    logic setup_ph;                                 // APB setup cycle.
    logic wr_acc;                                   // Write taking effect this edge.
    logic wr_ctrl;                                  // Write to control, low lane on.
    logic wr_status;                                // Write to status.
    logic wr_mask;                                  // Write to mask.
    logic new_enable;                               // Write that turns the detector on.
    logic stable;                                   // Reference is ready.
    logic cond;                                     // Supply is on the chosen side.
    logic detect_set;                               // Flag sets this cycle.

    // True when the address hits one of the three registers.
    function automatic logic addr_mapped(input logic [APB_ADDR_W-1:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_MASK);
    endfunction : addr_mapped

    // ==========================================================================
    // Input synchronisation
    // ==========================================================================
    // The comparator output is analog-timed, so it passes two flops first.
    // The synchroniser adds two cycles of latency before a crossing is seen.
    svd_sync #(
        .WIDTH(1)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(supply_at_or_above),
        .sync_out(above_s)
    );

    // ==========================================================================
    // APB decode
    // ==========================================================================
    // The slave never stalls, so every access phase completes at once.
    // Only the low byte lane carries fields, so pstrb[0] alone gates writes.
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign wr_ctrl = wr_acc && (paddr == OFS_CTRL) && pstrb[0];
    assign wr_status = wr_acc && (paddr == OFS_STATUS) && pstrb[0];
    assign wr_mask = wr_acc && (paddr == OFS_MASK) && pstrb[0];
    assign pready = psel && penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

    // Read data and error are taken in the setup cycle so that the data output
    // comes from flops; a status change in the one access cycle shows next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            pslverr_q <= !addr_mapped(paddr);
            prdata_q <= '0;
            if (!pwrite) begin
                unique case (paddr)
                    OFS_CTRL: begin
                        // Bit 6 is never stored, so it always reads zero.
                        prdata_q <= {{(APB_DATA_W-CTRL_W){1'b0}},
                                     svd_ctrl_image(dir_q, stable, en_q, lvl_q)};
                    end
                    OFS_STATUS: begin
                        prdata_q <= {{(APB_DATA_W-INT_W){1'b0}}, status_q};
                    end
                    OFS_MASK: begin
                        prdata_q <= {{(APB_DATA_W-INT_W){1'b0}}, mask_q};
                    end
                    default: begin
                        // Unmapped reads return zero alongside the error.
                        prdata_q <= '0;
                    end
                endcase
            end
        end
    end

    // ==========================================================================
    // Control register
    // ==========================================================================
    // Writable fields take the low byte; bits 6 and 5 are dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Reset puts the detector off and the level to its reset code.
            dir_q <= LVL_RESET_DIR;
            en_q <= LVL_RESET_EN;
            lvl_q <= LVL_RESET;
            ext_q <= (LVL_RESET == LVL_EXTERNAL);
        end else if (wr_ctrl) begin
            dir_q <= pwdata[CTRL_DIR_BIT];
            en_q <= pwdata[CTRL_EN_BIT];
            lvl_q <= pwdata[LVL_MSB:LVL_LSB];
            ext_q <= (pwdata[LVL_MSB:LVL_LSB] == LVL_EXTERNAL);
        end
    end

    assign detector_enable = en_q;
    assign trip_level = lvl_q;
    assign external_trip_input = ext_q;

    // ==========================================================================
    // Reference settle tracker
    // ==========================================================================
    // Only a write that switches the detector from off to on restarts settling;
    // rewriting an enabled detector leaves a settled reference alone.
    assign new_enable = wr_ctrl && pwdata[CTRL_EN_BIT] && !en_q;
    assign stable = (ref_state_q == REF_READY);
    assign reference_stable = stable;

    // The analog reference settles in real time, not in clocks, so the count
    // is a least time at the nominal clock; a slower clock only lengthens it.
    // Next state of the tracker.
    always_comb begin
        ref_state_d = ref_state_q;
        unique case (ref_state_q)
            REF_OFF: begin
                if (new_enable) begin
                    ref_state_d = REF_SETTLE;
                end
            end
            REF_SETTLE: begin
                if (wr_ctrl && !pwdata[CTRL_EN_BIT]) begin
                    ref_state_d = REF_OFF;
                end else if (stab_cnt_q == CNT_DONE) begin
                    ref_state_d = REF_READY;
                end
            end
            REF_READY: begin
                if (wr_ctrl && !pwdata[CTRL_EN_BIT]) begin
                    ref_state_d = REF_OFF;
                end
            end
            default: begin
                // The spare code cannot be reached; fall back to off.
                ref_state_d = REF_OFF;
            end
        endcase
    end

    // Tracker state and settle counter; the counter clears on every new enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_state_q <= REF_OFF;
            stab_cnt_q <= '0;
        end else begin
            ref_state_q <= ref_state_d;
            if (new_enable || ref_state_d != REF_SETTLE) begin
                stab_cnt_q <= '0;
            end else if (stab_cnt_q != CNT_DONE) begin
                stab_cnt_q <= stab_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================================
    // Crossing detection and sticky flag
    // ==========================================================================
    // The flag is level-sensitive: it follows the synchronised comparator, so a
    // supply that stays past the trip point sets it again right after a clear.
    // Changing direction or level while enabled may flag from a stale sample,
    // so software should clear the flag after such a change.
    // Direction high watches for at-or-above, low for below the trip point.
    assign cond = dir_q ? above_s : !above_s;
    // Nothing sets the flag before the reference has settled.
    assign detect_set = stable && en_q && cond;

    // Write-one-to-clear, with a coincident set winning over the clear.
    // Losing a crossing is worse than a spare interrupt, hence this priority.
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~pwdata[INT_W-1:0];
        end
        if (detect_set) begin
            status_d[INT_DETECT_BIT] = 1'b1;
        end
    end

    // Status and mask registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            mask_q <= '0;
        end else begin
            status_q <= status_d;
            if (wr_mask) begin
                mask_q <= pwdata[INT_W-1:0];
            end
        end
    end

    // Interrupt and wake outputs come from flops, one cycle behind the cause.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
            wake_q <= detect_set && sleep_active;
        end
    end

    assign detect_irq = irq_q;
    assign wake_request = wake_q;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    // Checks on the design's own signals; a failure prints one line and goes on.
    a_flag_on_event: assert property (@(posedge pclk) disable iff (!presetn)
        detect_set |=> status_q[INT_DETECT_BIT])
        else $error("detect flag missed a qualifying crossing");

    a_dir_low_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!dir_q && above_s && !status_q[INT_DETECT_BIT]) |=> !status_q[INT_DETECT_BIT])
        else $error("falling mode flagged while supply was above trip");

    a_rsvd_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && paddr == OFS_CTRL) |-> !prdata[CTRL_RSVD_BIT])
        else $error("unimplemented control bit read as one");

    a_stable_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr == OFS_CTRL) |=> prdata[CTRL_STABLE_BIT] == $past(stable))
        else $error("stable bit read back wrong");

    a_no_set_unstable: assert property (@(posedge pclk) disable iff (!presetn)
        (!stable && !status_q[INT_DETECT_BIT] && !$past(stable)) |=> !status_q[INT_DETECT_BIT])
        else $error("flag set before reference was stable");

    a_settle_restart: assert property (@(posedge pclk) disable iff (!presetn)
        new_enable |=> !stable [*8])
        else $error("reference stable too soon after enable");

    a_settle_count: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(stable) |-> $past(stab_cnt_q) == CNT_DONE)
        else $error("reference became stable at wrong count");

    a_level_written: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> trip_level == $past(pwdata[LVL_MSB:LVL_LSB]))
        else $error("trip level not taken from write");

    a_external_select: assert property (@(posedge pclk) disable iff (!presetn)
        external_trip_input == (trip_level == LVL_EXTERNAL))
        else $error("external input select disagrees with trip level");

    a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (detect_set && sleep_active) |=> (wake_request && status_q[INT_DETECT_BIT]))
        else $error("crossing in sleep gave no wake request");

    a_reset_off: assert property (@(posedge pclk)
        $rose(presetn) |-> (!detector_enable && !stable && trip_level == LVL_RESET))
        else $error("control not at reset state after reset");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (status_q[INT_DETECT_BIT] && !(wr_status && pwdata[INT_DETECT_BIT]))
        |=> status_q[INT_DETECT_BIT])
        else $error("detect flag dropped without a clear");

    a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
        (status_q[INT_DETECT_BIT] && mask_q[INT_DETECT_BIT]) |=> detect_irq)
        else $error("interrupt missing for unmasked flag");

    a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(status_q & mask_q)) |=> !detect_irq)
        else $error("interrupt raised with no unmasked flag");

    a_wake_needs_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        wake_request |-> $past(sleep_active))
        else $error("wake request raised outside sleep");

    a_disable_off: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && !pwdata[CTRL_EN_BIT]) |=> (!reference_stable && !detector_enable))
        else $error("detector still on after disable");

    a_strobe_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && !pstrb[0]) |=> $stable(trip_level))
        else $error("write without low lane changed trip level");

endmodule : svd_top

// file: testbench/svd_top_tb_top.sv
/*
 * Self-checking bench for svd_top: APB register access, settle tracking,
 * crossing detection, sticky flag, mask, wake pulse and trip-level decode.
 * Assumes zero-wait APB and a shortened settle count of STAB cycles.
 */
`timescale 1ns/1ps
module svd_top_tb_top;
    import svd_pkg::*;
    // ==========================================================================
    // Signals
    // ==========================================================================
    localparam int STAB = 10; // Short settle count keeps the run brief.
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic supply_at_or_above, sleep_active, detector_enable, external_trip_input;
    logic reference_stable, detect_irq, wake_request;
    logic [LVL_W-1:0] trip_level;
    int mismatches, total_checks, n;
    svd_top #(.STAB_CNT(STAB)) u_svd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_at_or_above(supply_at_or_above), .sleep_active(sleep_active),
        .detector_enable(detector_enable), .trip_level(trip_level), .external_trip_input(external_trip_input),
        .reference_stable(reference_stable), .detect_irq(detect_irq), .wake_request(wake_request));
    // ==========================================================================
    // Tasks
    // ==========================================================================
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // Compares one value; the four-state compare lets no unknown pass.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // One APB transfer, entered just after a rising edge; waits for pready under a bound.
    task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [APB_DATA_W-1:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // ==========================================================================
    // Clock, watchdog and main sequence
    // ==========================================================================
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // A hang counts as a mismatch and goes to the closing report.
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        stop_test();
    end
    initial begin
        {psel, penable, pwrite, sleep_active} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        supply_at_or_above = 1'b1;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, '0);
        check("ctrl reset", 32'h05, rd);
        check("enable reset", 32'h0, detector_enable);
        $display("test reset done");
        // Every trip code, with the detector off so no settling starts.
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, OFS_CTRL, k);
            check("trip_level", k, trip_level);
            check("external", k == 15, external_trip_input);
        end
        $display("test levels done");
        // Rising mode; comparator already above, so only settling holds the flag off.
        apb(1'b1, OFS_CTRL, 32'hff);
        apb(1'b0, OFS_CTRL, '0);
        check("ctrl settling", 32'h9f, rd);
        apb(1'b0, OFS_STATUS, '0);
        check("status early", 32'h0, rd);
        n = 0;
        while (reference_stable !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        check("settle window", 32'h1, n >= STAB - 5 && n <= STAB + 2);
        apb(1'b0, OFS_CTRL, '0);
        check("ctrl stable", 32'hbf, rd);
        apb(1'b1, OFS_MASK, 32'h1);
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_STATUS, '0);
        check("status rise", 32'h1, rd);
        check("irq", 32'h1, detect_irq);
        supply_at_or_above <= 1'b0;
        repeat (5) @(posedge pclk);
        apb(1'b0, OFS_STATUS, '0);
        check("status sticky", 32'h1, rd);
        apb(1'b1, OFS_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        apb(1'b0, OFS_STATUS, '0);
        check("status cleared", 32'h0, rd);
        check("irq cleared", 32'h0, detect_irq);
        $display("test rising done");
        // Falling mode in sleep: the flag and a wake pulse follow; enable stays on, no restart.
        sleep_active <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h13);
        n = 0;
        while (wake_request !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check("wake seen", 32'h1, n < 20);
        sleep_active <= 1'b0;
        apb(1'b0, OFS_STATUS, '0);
        check("status fall", 32'h1, rd);
        check("still stable", 32'h1, reference_stable);
        apb(1'b1, OFS_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq masked", 32'h0, detect_irq);
        $display("test falling done");
        // Off, then on again: the condition persists but settling blocks the flag.
        apb(1'b1, OFS_CTRL, 32'h03);
        check("stable off", 32'h0, reference_stable);
        apb(1'b1, OFS_STATUS, 32'h1);
        repeat (5) @(posedge pclk);
        apb(1'b0, OFS_STATUS, '0);
        check("status off", 32'h0, rd);
        apb(1'b1, OFS_CTRL, 32'h13);
        apb(1'b0, OFS_STATUS, '0);
        check("status restart", 32'h0, rd);
        check("stable restart", 32'h0, reference_stable);
        $display("test restart done");
        // Unmapped word: error answer, zero data, no side effect.
        apb(1'b1, 12'h00c, 32'hff);
        check("slverr write", 32'h1, err);
        apb(1'b0, 12'h00c, '0);
        check("slverr read", 32'h1, err);
        check("unmapped data", 32'h0, rd);
        pstrb <= 4'he;
        apb(1'b1, OFS_CTRL, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, OFS_CTRL, '0);
        check("ctrl kept", 32'h33, rd);
        $display("test unmapped done");
        stop_test();
    end
endmodule : svd_top_tb_top
